// ===== serial_link_param_map.svh
// constants of the serial link parameter register bank: indices, fields, resets
// assumes a Wishbone slave with 32-bit data, one register per aligned word
`ifndef SERIAL_LINK_PARAM_MAP_SVH
`define SERIAL_LINK_PARAM_MAP_SVH

// register indices; the byte address is four times the index
`define SLP_IDX_OCTETS 12'h58C
`define SLP_IDX_FRAMES 12'h58D
`define SLP_IDX_CONVERTERS 12'h58E
`define SLP_IDX_CTRL_RES 12'h58F
`define SLP_IDX_SUBCLASS 12'h590
`define SLP_IDX_SAMPLES 12'h591
`define SLP_IDX_STATUS 12'h5F0

// field positions
`define SLP_FRAMES_MSB 4
`define SLP_CTRL_MSB 7
`define SLP_CTRL_LSB 6
`define SLP_RES_MSB 4
`define SLP_SUBCLASS_MSB 7
`define SLP_SUBCLASS_LSB 5
`define SLP_NP_MSB 4
`define SLP_SAMPLES_MSB 4

// reset values
`define SLP_RST_OCTETS 8'h01
`define SLP_RST_FRAMES 5'h1F
`define SLP_RST_CONVERTERS 8'h01
`define SLP_RST_CTRL 2'h0
`define SLP_RST_RES 5'h0F
`define SLP_RST_SUBCLASS 3'h1
`define SLP_RST_NP 5'h0F
`define SLP_RST_SAMPLES 5'h00

// cycles from a request edge to the acknowledge
`define SLP_ACK_LATENCY 1

`endif

// ===== serial_link_param_pkg.sv
// types shared by the serial link parameter register bank
// assumes the constants of serial_link_param_map.svh
package serial_link_param_pkg;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  typedef logic [4:0] code5_t;
  typedef logic [1:0] cs_code_t;
  typedef logic [2:0] subclass_t;
  typedef logic [2:0] cs_mask_t;

endpackage

// ===== cfg_field.sv
// one writable configuration field with a reset value
// assumes the caller forms the write strobe and slices the write data
`timescale 1ns/1ns
`default_nettype none
module cfg_field #(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_ff;

  // elaboration check: a field needs at least one bit
  if (W < 1) begin : g_bad_width
    $error("cfg_field width must be at least one");
  end

  // clock enable low freezes the stored value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= RST;
    end else if (ce_i && we_i) begin
      q_ff <= wdata_i;
    end
  end

  assign q_o = q_ff;

endmodule
`default_nettype wire

// ===== link_param_check.sv
// combinational checks and derived values of the link parameters
// assumes raw field codes from the register bank on the same clock
`timescale 1ns/1ns
`default_nettype none
module link_param_check
  import serial_link_param_pkg::*;
(
  input wire logic [7:0] octets_code_i,
  input wire serial_link_param_pkg::code5_t frames_code_i,
  input wire serial_link_param_pkg::cs_code_t cs_code_i,
  input wire serial_link_param_pkg::code5_t res_code_i,
  input wire serial_link_param_pkg::code5_t np_code_i,
  output serial_link_param_pkg::cs_mask_t cs_mask_o,
  output logic mf_ok_o,
  output logic frames_legal_o,
  output logic res_legal_o,
  output logic np_legal_o
);

  logic [8:0] f_eff;
  logic [5:0] k_eff;
  logic [14:0] fk;

  // effective values are the codes plus one
  assign f_eff = {1'b0, octets_code_i} + 9'h001;
  assign k_eff = {1'b0, frames_code_i} + 6'h01;
  assign fk = 15'(f_eff * k_eff);
  // a product divisible by four has its two low bits clear
  assign mf_ok_o = (fk[1:0] == 2'h0);

  // control bit 2 goes first, bit 0 only with all three selected
  assign cs_mask_o[2] = (cs_code_i != 2'h0);
  assign cs_mask_o[1] = (cs_code_i[1] == 1'b1);
  assign cs_mask_o[0] = (cs_code_i == 2'h3);

  // listed K values are the multiples of four from 4 to 32
  assign frames_legal_o = (k_eff[1:0] == 2'h0);
  // resolution 7 to 16 bits
  assign res_legal_o = (res_code_i >= 5'h06) && (res_code_i <= 5'h0F);
  // only 8 or 16 bits per sample
  assign np_legal_o = (np_code_i == 5'h07) || (np_code_i == 5'h0F);

endmodule
`default_nettype wire

// ===== serial_link_param_regs.sv
// serial link parameter register bank of the transmit framer
// assumes a classic Wishbone master on clk_i; the framer reads the outputs
`include "serial_link_param_map.svh"
`timescale 1ns/1ns
`default_nettype none
module serial_link_param_regs
  import serial_link_param_pkg::*;
#(
  parameter int ADR_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // effective link parameters toward the framer
  output logic [5:0] frames_per_mf_o,
  output logic [8:0] converters_o,
  output logic [1:0] control_bits_o,
  output serial_link_param_pkg::cs_mask_t cs_include_o,
  output logic [5:0] resolution_o,
  output serial_link_param_pkg::subclass_t subclass_o,
  output logic [5:0] sample_bits_o,
  output logic [5:0] samples_per_frame_o,
  output logic [8:0] octets_per_frame_o,
  output logic mf_ok_o
);

  import serial_link_param_pkg::*;

  // elaboration check: the word index needs address bits 13:2
  if (ADR_W < 14) begin : g_bad_adr
    $error("address must reach the highest register index");
  end

  bus_state_t state_ff;
  bus_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic [11:0] word_idx;
  logic req;
  logic wr_take;
  logic low_lane;
  logic hit_frames;
  logic hit_ctrl_res;
  logic hit_subclass;
  logic hit_octets;
  logic hit_converters;
  logic hit_samples;
  logic hit_status;

  code5_t frames_code;
  cs_code_t cs_code;
  code5_t res_code;
  subclass_t subclass_code;
  code5_t np_code;
  logic [7:0] octets_code;
  logic [7:0] converters_code;
  code5_t samples_code;

  cs_mask_t cs_mask;
  logic mf_ok;
  logic frames_legal;
  logic res_legal;
  logic np_legal;

  logic [7:0] frames_byte;
  logic [7:0] ctrl_res_byte;
  logic [7:0] subclass_byte;
  logic [7:0] samples_byte;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  logic [5:0] frames_eff_ff;
  logic [8:0] converters_eff_ff;
  logic [1:0] control_bits_ff;
  cs_mask_t cs_include_ff;
  logic [5:0] resolution_ff;
  subclass_t subclass_ff;
  logic [5:0] sample_bits_ff;
  logic [5:0] samples_eff_ff;
  logic [8:0] octets_eff_ff;
  logic mf_ok_ff;

  // next values of the framer registers
  logic [5:0] nxt_frames_eff;
  logic [8:0] nxt_converters_eff;
  logic [1:0] nxt_control_bits;
  cs_mask_t nxt_cs_include;
  logic [5:0] nxt_resolution;
  subclass_t nxt_subclass;
  logic [5:0] nxt_sample_bits;
  logic [5:0] nxt_samples_eff;
  logic [8:0] nxt_octets_eff;
  logic nxt_mf_ok;

  // address decode; registers take one aligned word each
  assign word_idx = adr_i[13:2];
  assign hit_octets = (word_idx == `SLP_IDX_OCTETS);
  assign hit_frames = (word_idx == `SLP_IDX_FRAMES);
  assign hit_converters = (word_idx == `SLP_IDX_CONVERTERS);
  assign hit_ctrl_res = (word_idx == `SLP_IDX_CTRL_RES);
  assign hit_subclass = (word_idx == `SLP_IDX_SUBCLASS);
  assign hit_samples = (word_idx == `SLP_IDX_SAMPLES);
  assign hit_status = (word_idx == `SLP_IDX_STATUS);

  // the write lands at the edge where the master sees ack
  assign req = cyc_i && stb_i;
  assign low_lane = sel_i[0];
  assign wr_take = req && we_i && low_lane && (state_ff == BUS_ACK);

  // link values fixed by the lane setup; writes to them are dropped
  assign octets_code = `SLP_RST_OCTETS;
  assign converters_code = `SLP_RST_CONVERTERS;
  assign samples_code = `SLP_RST_SAMPLES;

  // writable fields; each holds only its own bits of the written byte
  // K code, bits 4:0 of its word
  cfg_field #(
    .W(5),
    .RST(`SLP_RST_FRAMES)
  ) u_frames (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr_take && hit_frames),
    .wdata_i(dat_i[`SLP_FRAMES_MSB:0]),
    .q_o(frames_code)
  );

  // control-bit count, bits 7:6 of the shared word
  cfg_field #(
    .W(2),
    .RST(`SLP_RST_CTRL)
  ) u_ctrl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr_take && hit_ctrl_res),
    .wdata_i(dat_i[`SLP_CTRL_MSB:`SLP_CTRL_LSB]),
    .q_o(cs_code)
  );

  // resolution code, bits 4:0 of the same word; bit 5 is never stored
  cfg_field #(
    .W(5),
    .RST(`SLP_RST_RES)
  ) u_res (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr_take && hit_ctrl_res),
    .wdata_i(dat_i[`SLP_RES_MSB:0]),
    .q_o(res_code)
  );

  // subclass, bits 7:5
  cfg_field #(
    .W(3),
    .RST(`SLP_RST_SUBCLASS)
  ) u_subclass (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr_take && hit_subclass),
    .wdata_i(dat_i[`SLP_SUBCLASS_MSB:`SLP_SUBCLASS_LSB]),
    .q_o(subclass_code)
  );

  // bits-per-sample code, bits 4:0 of the subclass word
  cfg_field #(
    .W(5),
    .RST(`SLP_RST_NP)
  ) u_np (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr_take && hit_subclass),
    .wdata_i(dat_i[`SLP_NP_MSB:0]),
    .q_o(np_code)
  );

  // derived values and sanity flags
  link_param_check u_check (
    .octets_code_i(octets_code),
    .frames_code_i(frames_code),
    .cs_code_i(cs_code),
    .res_code_i(res_code),
    .np_code_i(np_code),
    .cs_mask_o(cs_mask),
    .mf_ok_o(mf_ok),
    .frames_legal_o(frames_legal),
    .res_legal_o(res_legal),
    .np_legal_o(np_legal)
  );

  // read images; reserved bits read as zero
  assign frames_byte = {3'h0, frames_code};
  assign ctrl_res_byte = {cs_code, 1'b0, res_code};
  assign subclass_byte = {subclass_code, np_code};
  assign samples_byte = {3'h0, samples_code};
  assign status_byte = {4'h0, np_legal, res_legal, frames_legal, mf_ok};

  // read mux; an unmapped index still acks and reads zero
  assign rd_byte = hit_octets ? octets_code :
                   hit_frames ? frames_byte :
                   hit_converters ? converters_code :
                   hit_ctrl_res ? ctrl_res_byte :
                   hit_subclass ? subclass_byte :
                   hit_samples ? samples_byte :
                   hit_status ? status_byte : 8'h00;

  // bus sequencing: ack one cycle after the request, dropped the cycle after
  always_comb begin
    nxt_state = state_ff;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      BUS_IDLE: begin
        if (req) begin
          nxt_state = BUS_ACK;
          nxt_rdata = {24'h000000, rd_byte};
        end
      end
      BUS_ACK: begin
        nxt_state = BUS_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= BUS_IDLE;
      rdata_ff <= 32'h00000000;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
    end
  end

  assign ack_o = (state_ff == BUS_ACK);
  assign dat_o = rdata_ff;

  // effective values are the codes plus one; a code of 31 still fits in six bits
  assign nxt_frames_eff = {1'b0, frames_code} + 6'h01;
  assign nxt_converters_eff = {1'b0, converters_code} + 9'h001;
  assign nxt_control_bits = cs_code;
  assign nxt_cs_include = cs_mask;
  assign nxt_resolution = {1'b0, res_code} + 6'h01;
  assign nxt_subclass = subclass_code;
  assign nxt_sample_bits = {1'b0, np_code} + 6'h01;
  assign nxt_samples_eff = {1'b0, samples_code} + 6'h01;
  assign nxt_octets_eff = {1'b0, octets_code} + 9'h001;
  assign nxt_mf_ok = mf_ok;

  // registered so the framer sees clean edges; reset loads the field defaults, plus one for all but the control bits, subclass and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frames_eff_ff <= {1'b0, `SLP_RST_FRAMES} + 6'h01;
      converters_eff_ff <= {1'b0, `SLP_RST_CONVERTERS} + 9'h001;
      control_bits_ff <= `SLP_RST_CTRL;
      cs_include_ff <= 3'h0;
      resolution_ff <= {1'b0, `SLP_RST_RES} + 6'h01;
      subclass_ff <= `SLP_RST_SUBCLASS;
      sample_bits_ff <= {1'b0, `SLP_RST_NP} + 6'h01;
      samples_eff_ff <= {1'b0, `SLP_RST_SAMPLES} + 6'h01;
      octets_eff_ff <= {1'b0, `SLP_RST_OCTETS} + 9'h001;
      mf_ok_ff <= 1'b1;
    end else if (ce_i) begin
      frames_eff_ff <= nxt_frames_eff;
      converters_eff_ff <= nxt_converters_eff;
      control_bits_ff <= nxt_control_bits;
      cs_include_ff <= nxt_cs_include;
      resolution_ff <= nxt_resolution;
      subclass_ff <= nxt_subclass;
      sample_bits_ff <= nxt_sample_bits;
      samples_eff_ff <= nxt_samples_eff;
      octets_eff_ff <= nxt_octets_eff;
      mf_ok_ff <= nxt_mf_ok;
    end
  end

  // the bank does not refuse a bad K; it only flags it in the status word
  assign frames_per_mf_o = frames_eff_ff;
  assign converters_o = converters_eff_ff;
  assign control_bits_o = control_bits_ff;
  assign cs_include_o = cs_include_ff;
  assign resolution_o = resolution_ff;
  assign subclass_o = subclass_ff;
  assign sample_bits_o = sample_bits_ff;
  assign samples_per_frame_o = samples_eff_ff;
  assign octets_per_frame_o = octets_eff_ff;
  assign mf_ok_o = mf_ok_ff;

endmodule
`default_nettype wire

// ===== serial_link_param_monitor.sv
// concurrent checks on the ports of the serial link parameter register bank
// assumes one clock domain and a classic Wishbone master on the bus side
`include "serial_link_param_map.svh"
`timescale 1ns/1ns
`default_nettype none
module serial_link_param_monitor
  import serial_link_param_pkg::*;
#(
  parameter int ADR_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [5:0] frames_per_mf_o,
  input wire logic [8:0] converters_o,
  input wire logic [1:0] control_bits_o,
  input wire serial_link_param_pkg::cs_mask_t cs_include_o,
  input wire logic [5:0] samples_per_frame_o,
  input wire logic [8:0] octets_per_frame_o,
  input wire logic mf_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus handshake: one-cycle answer, one-cycle pulse, never unasked
  property p_ack_next; cyc_i && stb_i && ce_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_pulse; ack_o && ce_i |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_cause; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  // link parameter relations
  property p_k_range; frames_per_mf_o inside {[6'h01:6'h20]}; endproperty
  a_k_range: assert property (p_k_range) else $error("K out of range");
  // a write to the K word reaches the framer one edge after it lands
  property p_k_write;
    (ack_o && cyc_i && stb_i && we_i && sel_i[0] && ce_i && adr_i[13:2] == `SLP_IDX_FRAMES)
      ##1 ce_i |=> frames_per_mf_o == {1'b0, $past(dat_i[4:0], 2)} + 6'h01;
  endproperty
  a_k_write: assert property (p_k_write) else $error("K write not applied");
  property p_m_fixed; converters_o == 9'h002; endproperty
  a_m_fixed: assert property (p_m_fixed) else $error("M not two");
  property p_cs_order;
    cs_include_o == {control_bits_o != 2'h0, control_bits_o[1], control_bits_o == 2'h3};
  endproperty
  a_cs_order: assert property (p_cs_order) else $error("control bit order");
  property p_s_fixed; samples_per_frame_o == 6'h01; endproperty
  a_s_fixed: assert property (p_s_fixed) else $error("S not one");
  property p_f_fixed; octets_per_frame_o == 9'h002; endproperty
  a_f_fixed: assert property (p_f_fixed) else $error("F not two");
  // product modulo four depends only on the two low bits of each factor
  property p_mf_ok;
    mf_ok_o == ((octets_per_frame_o[1:0] * frames_per_mf_o[1:0]) % 4 == 0);
  endproperty
  a_mf_ok: assert property (p_mf_ok) else $error("multiframe flag wrong");
  c_ack: cover property ($rose(ack_o));
  c_cs_all: cover property (cs_include_o == 3'h7);
  c_mf_bad: cover property (!mf_ok_o);
  c_frozen: cover property (cyc_i && stb_i && !ce_i);
endmodule
bind serial_link_param_regs serial_link_param_monitor #(.ADR_W(ADR_W)) u_mon (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .frames_per_mf_o(frames_per_mf_o), .converters_o(converters_o),
  .control_bits_o(control_bits_o), .cs_include_o(cs_include_o),
  .samples_per_frame_o(samples_per_frame_o), .octets_per_frame_o(octets_per_frame_o),
  .mf_ok_o(mf_ok_o));
`default_nettype wire

// ===== tb.sv
// self-checking bench of the serial link parameter register bank
// assumes the one-cycle Wishbone answer and the register map of the hand-over
`include "serial_link_param_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  import serial_link_param_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
  logic [13:0] adr_i = 14'h0000;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h0;
  logic ack_o, mf_ok_o;
  logic [5:0] frames_per_mf_o, resolution_o, sample_bits_o, samples_per_frame_o;
  logic [8:0] converters_o, octets_per_frame_o;
  logic [1:0] control_bits_o;
  cs_mask_t cs_include_o;
  subclass_t subclass_o;
  int err_total = 0, tests_run = 0;

  serial_link_param_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .frames_per_mf_o(frames_per_mf_o), .converters_o(converters_o),
    .control_bits_o(control_bits_o), .cs_include_o(cs_include_o),
    .resolution_o(resolution_o), .subclass_o(subclass_o), .sample_bits_o(sample_bits_o),
    .samples_per_frame_o(samples_per_frame_o), .octets_per_frame_o(octets_per_frame_o),
    .mf_ok_o(mf_ok_o));

  initial forever #5 clk_i = ~clk_i;

  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle, started right after an edge; returns two idle edges later,
  // when the framer outputs have taken a written value
  task automatic wb(input logic [11:0] idx, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    chk({31'h0, ack_o}, 32'h1, "ack");
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string what);
    wb(idx, 1'h0, 32'h0, 4'hF);
    chk(rd, exp, what);
  endtask

  task automatic t_reset();
    rd_chk(`SLP_IDX_OCTETS, 32'h01, "F code");
    rd_chk(`SLP_IDX_FRAMES, 32'h1F, "K code");
    rd_chk(`SLP_IDX_CONVERTERS, 32'h01, "M code");
    rd_chk(`SLP_IDX_CTRL_RES, 32'h0F, "CS N");
    rd_chk(`SLP_IDX_SUBCLASS, 32'h2F, "subclass");
    rd_chk(`SLP_IDX_SAMPLES, 32'h00, "S code");
    chk({frames_per_mf_o, resolution_o, sample_bits_o, samples_per_frame_o},
        {6'h20, 6'h10, 6'h10, 6'h01}, "reset K N N' S");
    chk({converters_o, octets_per_frame_o, control_bits_o, subclass_o, mf_ok_o},
        {9'h002, 9'h002, 2'h0, 3'h1, 1'h1}, "reset M F CS");
  endtask

  // with F of two the product divides by four exactly when K is even
  task automatic t_frames();
    logic [4:0] codes [8] = '{5'h03, 5'h07, 5'h0C, 5'h0F, 5'h13, 5'h17, 5'h1B, 5'h00};
    foreach (codes[i]) begin
      wb(`SLP_IDX_FRAMES, 1'h1, {27'h0, codes[i]}, 4'hF);
      rd_chk(`SLP_IDX_FRAMES, {27'h0, codes[i]}, "K readback");
      rd_chk(`SLP_IDX_STATUS, {28'h0, 2'h3, codes[i][1:0] == 2'h3, codes[i][0]},
             "status");
      chk(frames_per_mf_o, codes[i] + 32'h1, "K");
      chk(mf_ok_o, codes[i][0], "mf flag");
    end
    wb(`SLP_IDX_FRAMES, 1'h1, 32'h1F, 4'hF);
    chk(frames_per_mf_o, 32'h20, "K restored");
  endtask

  // reserved bit 5 is written high and must read back low
  task automatic t_ctrl();
    logic [4:0] res;
    for (int cs = 0; cs < 4; cs++) begin
      res = (cs == 3) ? 5'h0F : 5'h06 + 5'(cs);
      wb(`SLP_IDX_CTRL_RES, 1'h1, {24'h0, 2'(cs), 1'h1, res}, 4'hF);
      rd_chk(`SLP_IDX_CTRL_RES, {24'h0, 2'(cs), 1'h0, res}, "CS N readback");
      chk(control_bits_o, cs, "CS");
      chk(cs_include_o, {cs != 0, cs >= 2, cs == 3}, "CS order");
      chk(resolution_o, res + 32'h1, "N");
    end
    wb(`SLP_IDX_CTRL_RES, 1'h1, 32'h05, 4'hF);
    chk(resolution_o, 32'h06, "N stored out of range");
    rd_chk(`SLP_IDX_STATUS, 32'h0B, "N code flagged");
  endtask

  task automatic t_subclass();
    wb(`SLP_IDX_SUBCLASS, 1'h1, 32'h07, 4'hF);
    rd_chk(`SLP_IDX_SUBCLASS, 32'h07, "subclass readback");
    chk({subclass_o, sample_bits_o}, {3'h0, 6'h08}, "subclass 0 N' 8");
    wb(`SLP_IDX_SUBCLASS, 1'h1, 32'h0A, 4'hF);
    rd_chk(`SLP_IDX_STATUS, 32'h03, "N' code flagged");
    wb(`SLP_IDX_SUBCLASS, 1'h1, 32'h2F, 4'hF);
    chk({subclass_o, sample_bits_o}, {3'h1, 6'h10}, "subclass 1 N' 16");
  endtask

  // read-only places, a dropped byte lane and an unmapped index
  task automatic t_refused();
    logic [11:0] idx [3] = '{`SLP_IDX_OCTETS, `SLP_IDX_CONVERTERS, `SLP_IDX_SAMPLES};
    logic [31:0] exp [3] = '{32'h01, 32'h01, 32'h00};
    foreach (idx[i]) begin
      wb(idx[i], 1'h1, 32'hFF, 4'hF);
      rd_chk(idx[i], exp[i], "read only");
    end
    chk({converters_o, octets_per_frame_o, samples_per_frame_o},
        {9'h002, 9'h002, 6'h01}, "fixed M F S");
    wb(`SLP_IDX_FRAMES, 1'h1, 32'h03, 4'hE);
    rd_chk(`SLP_IDX_FRAMES, 32'h1F, "lane 0 off");
    wb(12'h100, 1'h1, 32'hFF, 4'hF);
    rd_chk(12'h100, 32'h00, "unmapped");
  endtask

  // enable low holds a request off; it is taken and lands once the enable returns
  task automatic t_freeze();
    int n;
    n = 0;
    ce_i <= 1'h0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= 1'h1;
    adr_i <= {`SLP_IDX_FRAMES, 2'h0};
    dat_i <= 32'h07;
    sel_i <= 4'hF;
    repeat (3) begin
      @(posedge clk_i);
      chk({31'h0, ack_o}, 32'h0, "ack while frozen");
    end
    chk(frames_per_mf_o, 32'h20, "K frozen");
    ce_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    chk({31'h0, ack_o}, 32'h1, "ack after freeze");
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk(frames_per_mf_o, 32'h08, "K after freeze");
    wb(`SLP_IDX_FRAMES, 1'h1, 32'h1F, 4'hF);
  endtask

  // a second reset after the fields were rewritten brings every default back
  task automatic t_rerun();
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_frames();
    t_ctrl();
    t_subclass();
    t_freeze();
    t_refused();
    t_rerun();
    wrap_up();
  end

  // about sixty bus cycles of four clocks each fit well inside this span
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
